// ---- pfr_read_port.sv ----
// How it works
// - setting read strobe bit 0 with the space select set starts a fetch.
// - the flash is read during the second instruction cycle after the set.
// - the instruction in that second cycle is flagged as not executed.
// - the word sits in the data registers in the cycle after the fetch.
// - data registers hold until another read or a software write.
// - a write strobe set while the space select is 1 is dropped at once.
// - the read strobe is cleared by hardware; software can only set it.
// - space select clear makes the read use only the low address and data.
`timescale 1ns/1ps
module pfr_read_port
   import pfr_pkg::*;
#(
   parameter int DIV = INSTR_DIV,
   parameter int ADDR_W = 12
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output pfr_flash_req_type flashReq,
   input wire logic [PROG_WORD_W-1:0] flashData,
   output pfr_ee_req_type eeReq,
   input wire logic [7:0] eeData,
   input wire logic eeWriteDone,
   output logic instrSuppress,
   output logic instrTick
);

   if (DIV < 2 || ADDR_W < 12) begin : g_check
      $error("pfr_read_port: DIV must be >= 2 and ADDR_W >= 12");
   end

   localparam int CW = $clog2(DIV);

   function automatic logic [10:0] regIndex(input logic [ADDR_W-1:0] a);
      regIndex = {1'b0, a[11:2]};
   endfunction : regIndex

   function automatic logic isMapped(input logic [10:0] i);
      isMapped = i == {1'b0, IDX_FLAGS_ONE}
         || i == {1'b0, IDX_IRQ_ENABLE_ONE}
         || i == {1'b0, IDX_DATA_LOW} || i == {1'b0, IDX_ADDR_LOW}
         || i == {1'b0, IDX_DATA_HIGH} || i == {1'b0, IDX_ADDR_HIGH}
         || i == {1'b0, IDX_CONTROL} || i == {1'b0, IDX_UNLOCK_PORT};
   endfunction : isMapped

   logic [7:0] flagsOne;
   logic [7:0] irqEnableOne;
   logic [7:0] nvmDataLow;
   logic [7:0] nvmAddrLow;
   logic [DATA_HIGH_W-1:0] nvmDataHigh;
   logic [ADDR_HIGH_W-1:0] nvmAddrHigh;
   logic spaceSelect;
   logic writePermit;
   logic writeAbortFlag;
   logic writeStrobe;
   logic readStrobe;
   pfr_state_type state;
   pfr_state_type next_state;
   logic [CW-1:0] divCount;
   logic [ADDR_W-1:0] awAddrHeld;
   logic awHave;
   logic [7:0] wByteHeld;
   logic wLaneOn;
   logic wHave;

   // instruction cycle enable from the core clock
   wire tickNow = divCount == CW'(DIV - 1);

   always_ff @(posedge clk) begin
      if (!rstn) begin
         divCount <= '0;
         instrTick <= 1'b0;
      end else begin
         divCount <= tickNow ? '0 : divCount + CW'(1);
         instrTick <= tickNow;
      end
   end

   // write channel: address and data taken in either order
   wire doWrite = awHave && wHave && !bvalid;
   wire [10:0] wIdx = regIndex(awAddrHeld);
   wire wMapped = isMapped(wIdx);
   wire wEn = doWrite && wLaneOn;
   wire wrFlags = wEn && wIdx == {1'b0, IDX_FLAGS_ONE};
   wire wrIrqEn = wEn && wIdx == {1'b0, IDX_IRQ_ENABLE_ONE};
   wire wrDataLow = wEn && wIdx == {1'b0, IDX_DATA_LOW};
   wire wrAddrLow = wEn && wIdx == {1'b0, IDX_ADDR_LOW};
   wire wrDataHigh = wEn && wIdx == {1'b0, IDX_DATA_HIGH};
   wire wrAddrHigh = wEn && wIdx == {1'b0, IDX_ADDR_HIGH};
   wire wrControl = wEn && wIdx == {1'b0, IDX_CONTROL};

   always_ff @(posedge clk) begin
      if (!rstn) begin
         awready <= 1'b1;
         wready <= 1'b1;
         awHave <= 1'b0;
         wHave <= 1'b0;
         awAddrHeld <= '0;
         wByteHeld <= RST_BYTE;
         wLaneOn <= 1'b0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            awAddrHeld <= awaddr;
            awHave <= 1'b1;
            awready <= 1'b0;
         end
         if (wvalid && wready) begin
            wByteHeld <= wdata[7:0];
            wLaneOn <= wstrb[0];
            wHave <= 1'b1;
            wready <= 1'b0;
         end
         if (doWrite) begin
            bvalid <= 1'b1;
            bresp <= wMapped ? RESP_OKAY : RESP_SLVERR;
            awHave <= 1'b0;
            wHave <= 1'b0;
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   // read strobe only starts from idle; a zero write leaves it alone
   wire newSpace = wByteHeld[CTL_SPACE_BIT];
   wire startRead = wrControl && wByteHeld[CTL_READ_BIT]
      && state == ST_IDLE;
   wire newPermit = wByteHeld[CTL_PERMIT_BIT];
   wire startWrite = wrControl && wByteHeld[CTL_WRITE_BIT]
      && newPermit && !newSpace;
   wire fetchDone = state == ST_FETCH && tickNow;
   wire eeDone = state == ST_EE_READ;

   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: begin
            if (startRead) begin
               next_state = newSpace ? ST_WAIT : ST_EE_READ;
            end
         end
         ST_WAIT: begin
            if (tickNow) begin
               next_state = ST_FETCH;
            end
         end
         ST_FETCH: begin
            if (tickNow) begin
               next_state = ST_IDLE;
            end
         end
         ST_EE_READ: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         state <= ST_IDLE;
         readStrobe <= 1'b0;
      end else begin
         state <= next_state;
         if (startRead) begin
            readStrobe <= 1'b1;
         end else if (fetchDone || eeDone) begin
            readStrobe <= 1'b0;
         end
      end
   end

   // flash is driven for the whole second instruction cycle
   always_ff @(posedge clk) begin
      if (!rstn) begin
         flashReq <= '0;
         instrSuppress <= 1'b0;
      end else begin
         flashReq.read <= next_state == ST_FETCH;
         instrSuppress <= next_state == ST_FETCH;
         if (startRead) begin
            flashReq.addr <= {nvmAddrHigh, nvmAddrLow};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         eeReq <= '0;
      end else begin
         eeReq.read <= startRead && !newSpace;
         eeReq.write <= startWrite;
         if (startRead || startWrite) begin
            eeReq.addr <= nvmAddrLow;
            eeReq.wdata <= nvmDataLow;
         end
      end
   end

   // a fetch landing with a software write keeps the fetched word
   always_ff @(posedge clk) begin
      if (!rstn) begin
         nvmDataLow <= RST_BYTE;
         nvmDataHigh <= '0;
      end else if (fetchDone) begin
         nvmDataLow <= flashData[7:0];
         nvmDataHigh <= flashData[PROG_WORD_W-1:8];
      end else if (eeDone) begin
         nvmDataLow <= eeData;
      end else begin
         if (wrDataLow) begin
            nvmDataLow <= wByteHeld;
         end
         if (wrDataHigh) begin
            nvmDataHigh <= wByteHeld[DATA_HIGH_W-1:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         nvmAddrLow <= RST_BYTE;
         nvmAddrHigh <= '0;
         irqEnableOne <= RST_BYTE;
      end else begin
         if (wrAddrLow) begin
            nvmAddrLow <= wByteHeld;
         end
         if (wrAddrHigh) begin
            nvmAddrHigh <= wByteHeld[ADDR_HIGH_W-1:0];
         end
         if (wrIrqEn) begin
            irqEnableOne <= wByteHeld;
         end
      end
   end

   // done flag: hardware set wins over a software clear
   always_ff @(posedge clk) begin
      if (!rstn) begin
         flagsOne <= RST_BYTE;
      end else begin
         if (wrFlags) begin
            flagsOne <= wByteHeld;
         end
         if (eeWriteDone && writeStrobe) begin
            flagsOne[FLAG_WRITE_DONE_BIT] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         spaceSelect <= RST_CONTROL[CTL_SPACE_BIT];
         writePermit <= RST_CONTROL[CTL_PERMIT_BIT];
         writeAbortFlag <= RST_CONTROL[CTL_ABORT_BIT];
         writeStrobe <= RST_CONTROL[CTL_WRITE_BIT];
      end else begin
         if (wrControl) begin
            spaceSelect <= newSpace;
            writePermit <= newPermit;
            writeAbortFlag <= wByteHeld[CTL_ABORT_BIT];
         end
         // write strobe in program space never sticks
         if (startWrite) begin
            writeStrobe <= 1'b1;
         end else if (eeWriteDone) begin
            writeStrobe <= 1'b0;
         end
      end
   end

   // read channel: one word per address, answered the next cycle
   wire [10:0] rIdx = regIndex(araddr);
   wire [7:0] ctlByte = {spaceSelect, 3'h0, writeAbortFlag, writePermit,
      writeStrobe, readStrobe};
   wire [7:0] rByte =
      rIdx == {1'b0, IDX_FLAGS_ONE} ? flagsOne :
      rIdx == {1'b0, IDX_IRQ_ENABLE_ONE} ? irqEnableOne :
      rIdx == {1'b0, IDX_DATA_LOW} ? nvmDataLow :
      rIdx == {1'b0, IDX_ADDR_LOW} ? nvmAddrLow :
      rIdx == {1'b0, IDX_DATA_HIGH} ? {2'h0, nvmDataHigh} :
      rIdx == {1'b0, IDX_ADDR_HIGH} ? {3'h0, nvmAddrHigh} :
      rIdx == {1'b0, IDX_CONTROL} ? ctlByte : 8'h00;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= {24'h00_0000, rByte};
         rresp <= isMapped(rIdx) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end

endmodule : pfr_read_port

// ---- pfr_pkg.sv ----
package pfr_pkg;

   // register indices; byte address is four times the index
   localparam logic [9:0] IDX_FLAGS_ONE = 10'h00c;
   localparam logic [9:0] IDX_IRQ_ENABLE_ONE = 10'h08c;
   localparam logic [9:0] IDX_DATA_LOW = 10'h10c;
   localparam logic [9:0] IDX_ADDR_LOW = 10'h10d;
   localparam logic [9:0] IDX_DATA_HIGH = 10'h10e;
   localparam logic [9:0] IDX_ADDR_HIGH = 10'h10f;
   localparam logic [9:0] IDX_CONTROL = 10'h18c;
   localparam logic [9:0] IDX_UNLOCK_PORT = 10'h18d;

   // control and flag field positions
   localparam int CTL_READ_BIT = 0;
   localparam int CTL_WRITE_BIT = 1;
   localparam int CTL_PERMIT_BIT = 2;
   localparam int CTL_ABORT_BIT = 3;
   localparam int CTL_SPACE_BIT = 7;
   localparam int FLAG_WRITE_DONE_BIT = 7;

   // implemented widths
   localparam int ADDR_HIGH_W = 5;
   localparam int DATA_HIGH_W = 6;
   localparam int PROG_ADDR_W = 13;
   localparam int PROG_WORD_W = 14;

   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] RST_CONTROL = 8'h00;

   // timing: core clock and instruction cycle rate
   localparam int CLK_HZ = 10_000_000;
   localparam int INSTR_HZ = 2_500_000;
   localparam int INSTR_DIV = CLK_HZ / INSTR_HZ;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_FETCH = 2'b10,
      ST_EE_READ = 2'b11
   } pfr_state_type;

   typedef struct packed {
      logic read;
      logic [PROG_ADDR_W-1:0] addr;
   } pfr_flash_req_type;

   typedef struct packed {
      logic read;
      logic write;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pfr_ee_req_type;

endpackage : pfr_pkg

// ---- pfr_read_port_asserts.sv ----
`timescale 1ns/1ps
module pfr_read_port_asserts
   import pfr_pkg::*;
#(
   parameter int DIV = INSTR_DIV
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic rvalid,
   input wire pfr_flash_req_type flashReq,
   input wire pfr_ee_req_type eeReq,
   input wire logic instrSuppress,
   input wire logic instrTick
);
   logic [7:0] runLen;
   // a counter, since a long repetition would choke the tools
   always_ff @(posedge clk) begin
      if (!rstn || !flashReq.read) begin
         runLen <= 8'h00;
      end else begin
         runLen <= runLen + 8'h01;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   a_fetch_length: assert property (
      $fell(flashReq.read) |-> runLen == DIV) else $error("fetch length");
   a_suppress_fetch: assert property (
      instrSuppress == flashReq.read) else $error("suppress mismatch");
   a_fetch_addr_hold: assert property (
      flashReq.read ##1 flashReq.read |-> $stable(flashReq.addr))
      else $error("fetch address moved");
   a_ee_pulse: assert property (
      eeReq.read |=> !eeReq.read) else $error("ee read not a pulse");
   a_tick_pulse: assert property (
      instrTick |=> !instrTick) else $error("tick not a pulse");
   a_read_answer: assert property (
      arvalid && arready |=> rvalid && !arready) else $error("read answer");
   a_write_answer: assert property (
      awvalid && awready && wvalid && wready |-> ##[2:3] bvalid)
      else $error("write answer");
   a_rdata_low: assert property (
      rvalid |-> rdata[31:8] == 24'h000000) else $error("rdata upper");
   a_fetch_on_tick: assert property (
      $changed(flashReq.read) |-> instrTick) else $error("fetch off tick");
endmodule : pfr_read_port_asserts

bind pfr_read_port pfr_read_port_asserts #(.DIV(DIV)) u_chk (.clk, .rstn,
   .awvalid, .awready, .wvalid, .wready, .bvalid, .arvalid, .arready,
   .rdata, .rvalid, .flashReq, .eeReq, .instrSuppress, .instrTick);

// ---- pfr_flash_model.sv ----
`timescale 1ns/1ps
module pfr_flash_model
   import pfr_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire pfr_flash_req_type flashReq,
   input wire pfr_ee_req_type eeReq,
   output logic [PROG_WORD_W-1:0] flashData,
   output logic [7:0] eeData,
   output logic eeWriteDone
);
   logic [7:0] churn;
   logic [7:0] eeStored;
   always_ff @(posedge clk) begin
      churn <= rstn ? churn + 8'h35 : 8'h00;
      eeWriteDone <= rstn && eeReq.write;
      eeStored <= !rstn ? 8'h00 : eeReq.write ? eeReq.wdata : eeStored;
   end
   // the last stored byte folds into ee reads, so the write data is seen
   // idle lines churn so a stale sample never matches
   assign flashData = flashReq.read ? {1'b1, flashReq.addr} ^ 14'h155a
      : {churn[5:0], churn};
   assign eeData = eeReq.read ? eeReq.addr ^ 8'hc3 ^ eeStored : ~churn;
endmodule : pfr_flash_model

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
   import pfr_pkg::*;
   localparam int DV = 2;
   logic clk = 1'b0, rstn = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'h0;
   logic [3:0] laneMask = 4'hf;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, eeWriteDone;
   logic instrSuppress, instrTick;
   logic [1:0] bresp, rresp;
   pfr_flash_req_type flashReq;
   pfr_ee_req_type eeReq;
   logic [13:0] flashData, word;
   logic [7:0] eeData, lo, hi;
   logic [9:0] qr[$];
   logic [1:0] qb[$];
   logic [9:0] resetList[8] = '{IDX_FLAGS_ONE, IDX_IRQ_ENABLE_ONE,
      IDX_DATA_LOW, IDX_ADDR_LOW, IDX_DATA_HIGH, IDX_ADDR_HIGH,
      IDX_CONTROL, IDX_UNLOCK_PORT};
   int miscompares = 0, checked = 0;

   pfr_read_port #(.DIV(DV), .ADDR_W(12)) i_dut (.clk, .rstn, .awaddr,
      .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
      .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready, .flashReq, .flashData, .eeReq, .eeData,
      .eeWriteDone, .instrSuppress, .instrTick);
   pfr_flash_model i_model (.clk, .rstn, .flashReq, .eeReq, .flashData,
      .eeData, .eeWriteDone);

   initial begin
      forever #50 clk = ~clk;
   end

   task automatic end_of_test;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input string nm, input logic [9:0] e, g);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   always @(posedge clk) begin
      if (rvalid === 1'b1 && rready === 1'b1) begin
         chk("read", qr.pop_front(), {rdata[7:0], rresp});
      end
      if (bvalid === 1'b1 && bready === 1'b1) begin
         chk("bresp", {8'h00, qb.pop_front()}, {8'h00, bresp});
      end
   end

   task automatic wr(input logic [9:0] ix, input logic [7:0] d,
         input logic [1:0] r);
      int n;
      qb.push_back(r);
      @(posedge clk);
      awaddr <= {ix, 2'b00};
      wdata <= {24'($urandom), d};
      wstrb <= laneMask;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      if (n == 50) begin
         miscompares++;
         end_of_test();
      end
   endtask : wr

   task automatic rd(input logic [9:0] ix, input logic [7:0] d,
         input logic [1:0] r);
      int n;
      qr.push_back({d, r});
      @(posedge clk);
      araddr <= {ix, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      if (n == 50) begin
         miscompares++;
         end_of_test();
      end
   endtask : rd

   initial begin
      void'($urandom(52578));
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      foreach (resetList[k]) rd(resetList[k], 8'h00, RESP_OKAY);
      rd(10'h3ff, 8'h00, RESP_SLVERR);
      wr(10'h3ff, 8'h77, RESP_SLVERR);
      lo = 8'($urandom);
      wr(IDX_IRQ_ENABLE_ONE, lo, RESP_OKAY);
      // low lane off: the write is answered but must not land
      laneMask = 4'he;
      wr(IDX_IRQ_ENABLE_ONE, ~lo, RESP_OKAY);
      laneMask = 4'hf;
      rd(IDX_IRQ_ENABLE_ONE, lo, RESP_OKAY);
      $display("reset and decode test done");
      for (int k = 0; k < 3; k++) begin
         lo = 8'($urandom);
         hi = 8'($urandom);
         word = {1'b1, hi[4:0], lo} ^ 14'h155a;
         wr(IDX_ADDR_HIGH, hi, RESP_OKAY);
         wr(IDX_ADDR_LOW, lo, RESP_OKAY);
         rd(IDX_ADDR_HIGH, {3'b000, hi[4:0]}, RESP_OKAY);
         wr(IDX_CONTROL, 8'h80, RESP_OKAY);
         wr(IDX_CONTROL, 8'h81, RESP_OKAY);
         repeat (2 * DV + 2) @(posedge clk);
         rd(IDX_DATA_LOW, word[7:0], RESP_OKAY);
         rd(IDX_DATA_HIGH, {2'b00, word[13:8]}, RESP_OKAY);
         rd(IDX_CONTROL, 8'h80, RESP_OKAY);
      end
      wr(IDX_CONTROL, 8'h80, RESP_OKAY);
      rd(IDX_DATA_LOW, word[7:0], RESP_OKAY);
      wr(IDX_DATA_LOW, 8'h5a, RESP_OKAY);
      rd(IDX_DATA_LOW, 8'h5a, RESP_OKAY);
      $display("program read test done");
      wr(IDX_CONTROL, 8'h86, RESP_OKAY);
      rd(IDX_CONTROL, 8'h84, RESP_OKAY);
      wr(IDX_CONTROL, 8'h06, RESP_OKAY);
      repeat (4) @(posedge clk);
      rd(IDX_CONTROL, 8'h04, RESP_OKAY);
      rd(IDX_FLAGS_ONE, 8'h80, RESP_OKAY);
      wr(IDX_FLAGS_ONE, 8'h00, RESP_OKAY);
      rd(IDX_FLAGS_ONE, 8'h00, RESP_OKAY);
      $display("write strobe test done");
      wr(IDX_ADDR_LOW, 8'h3c, RESP_OKAY);
      wr(IDX_DATA_HIGH, 8'h15, RESP_OKAY);
      wr(IDX_CONTROL, 8'h01, RESP_OKAY);
      repeat (4) @(posedge clk);
      rd(IDX_DATA_LOW, 8'h3c ^ 8'hc3 ^ 8'h5a, RESP_OKAY);
      rd(IDX_DATA_HIGH, 8'h15, RESP_OKAY);
      rd(IDX_CONTROL, 8'h00, RESP_OKAY);
      $display("data read test done");
      @(posedge clk);
      end_of_test();
   end
endmodule : tb
